//--- inc/mac_pkg.sv
// Constants, register map and carriers of the multiply-accumulate unit.
// Assumes a byte-wide register bus that is synchronous to the system clock.
package mac_pkg;
  localparam int ACC_W = 40;
  localparam int RND_W = 16;
  localparam logic [7:0] ADDR_A_LO = 8'ha4;
  localparam logic [7:0] ADDR_A_HI = 8'ha5;
  localparam logic [7:0] ADDR_STA = 8'hcf;
  localparam logic [7:0] ADDR_CFG = 8'hd7;
  localparam logic [7:0] ADDR_B_HI = 8'hf2;
  localparam logic [7:0] ADDR_B_LO = 8'hf3;
  localparam logic [7:0] ADDR_RND_HI = 8'hcd;
  localparam logic [7:0] ADDR_RND_LO = 8'hce;
  // Accumulator bytes, index 0 is bits 7..0, index 4 is bits 39..32
  localparam logic [4:0][7:0] ADDR_ACC = {8'h97, 8'h96, 8'h95, 8'h94, 8'h93};
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WMASK = 8'h3f;
  localparam logic [7:0] STA_RESET = 8'h04;
  localparam logic [7:0] STA_WMASK = 8'h0f;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] TOP_POS_EDGE = 8'h7f;
  localparam logic [7:0] TOP_NEG_EDGE = 8'h80;
  localparam logic [15:0] RND_HALF = 16'h8000;
  localparam logic [15:0] SAT_POS = 16'h7fff;
  localparam logic [15:0] SAT_NEG = 16'h8000;

  typedef struct packed {
    logic [1:0] unused;
    logic shift_request;
    logic shift_direction;
    logic accumulator_clear;
    logic saturation_enable;
    logic fractional_select;
    logic operation_select;
  } mac_cfg_t;

  typedef struct packed {
    logic [3:0] unused;
    logic hard_overflow_flag;
    logic zero_flag;
    logic soft_overflow_flag;
    logic negative_flag;
  } mac_status_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } mac_sfr_wr_t;

  // Value no longer fits a signed 32-bit word
  function automatic logic soft_ovf(input logic [ACC_W-1:0] v);
    return (|v[ACC_W-1:31]) && !(&v[ACC_W-1:31]);
  endfunction
endpackage

//--- hw/mac_mult.sv
// Registered signed multiplier, first pipeline stage of the unit.
// Assumes operands stay stable in the cycle that en_in is high.
`timescale 1ns/1ns
module mac_mult #(
  parameter int OPW = 16,
  parameter int PW = 40
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic en_in,
  input wire logic frac_in,
  input wire logic [OPW-1:0] a_in,
  input wire logic [OPW-1:0] b_in,
  output logic [PW-1:0] product_out
);
  logic signed [2*OPW-1:0] raw;
  logic [PW-1:0] ext;

  assign raw = $signed(a_in) * $signed(b_in);
  assign ext = {{(PW-2*OPW){raw[2*OPW-1]}}, raw};

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      product_out <= '0;
    end else if (ce_in && en_in) begin
      // Extended before shifting so minus one squared stays positive
      product_out <= frac_in ? {ext[PW-2:0], 1'b0} : ext;
    end
  end
endmodule

//--- hw/mac_round.sv
// Rounding engine: unbiased rounding of the middle word with saturation.
// Assumes the accumulator is steady in the cycle that en_in is high.
`timescale 1ns/1ns
module mac_round (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic en_in,
  input wire logic sat_in,
  input wire logic [mac_pkg::ACC_W-1:0] acc_in,
  output logic [mac_pkg::RND_W-1:0] rnd_out
);
  import mac_pkg::*;
  logic [15:0] hi;
  logic [15:0] lo;
  logic up;
  logic ovf;
  logic [15:0] next_rnd;

  assign hi = acc_in[31:16];
  assign lo = acc_in[15:0];

  always_comb begin
    up = (lo > RND_HALF) || ((lo == RND_HALF) && hi[0]);
    ovf = soft_ovf(acc_in) || (up && (hi == SAT_POS));
    if (sat_in && ovf) begin
      next_rnd = acc_in[ACC_W-1] ? SAT_NEG : SAT_POS;
    end else begin
      next_rnd = hi + {15'h0000, up};
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rnd_out <= '0;
    end else if (ce_in && en_in) begin
      rnd_out <= next_rnd;
    end
  end
endmodule

//--- hw/mac_unit.sv
// Multiply-accumulate unit top: byte registers, pipeline and status flags.
// Assumes one register bus master on the system clock; reads answer one cycle later.
`timescale 1ns/1ns
module mac_unit (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire mac_pkg::mac_sfr_wr_t SFR_WR_IN,
  input wire logic SFR_RD_IN,
  input wire logic [7:0] SFR_RADDR_IN,
  output logic [7:0] SFR_RDATA_OUT
);
  import mac_pkg::*;

  function automatic logic hit(input mac_sfr_wr_t w, input logic [7:0] a);
    return w.valid && (w.addr == a);
  endfunction

  logic [7:0] a_lo;
  logic [7:0] a_hi;
  logic [7:0] b_lo;
  logic [7:0] b_hi;
  mac_cfg_t cfg;
  mac_status_t sta;
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] product;
  logic [ACC_W-1:0] mac_sum;
  logic [ACC_W-1:0] sw_acc;
  logic [RND_W-1:0] rnd;
  logic stage1;
  logic stage2;
  logic stage3;
  logic shift_done;
  logic acc0_done;
  logic round_go;
  logic do_clear;
  logic do_mac;
  logic do_shift;
  logic sw_acc_wr;
  logic top_wrap;
  logic wr_cfg;
  logic wr_sta;
  logic wr_b_lo;

  assign wr_cfg = hit(SFR_WR_IN, ADDR_CFG);
  assign wr_sta = hit(SFR_WR_IN, ADDR_STA);
  assign wr_b_lo = hit(SFR_WR_IN, ADDR_B_LO);

  // Clear beats a finishing operation, which beats a pending shift
  assign do_clear = cfg.accumulator_clear;
  assign do_mac = stage2 && !do_clear;
  assign do_shift = cfg.shift_request && !do_clear && !stage2;
  assign round_go = stage3 || shift_done || acc0_done;

  // Operand bytes
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      a_lo <= BYTE_RESET;
      a_hi <= BYTE_RESET;
      b_lo <= BYTE_RESET;
      b_hi <= BYTE_RESET;
    end else if (CE_IN) begin
      if (hit(SFR_WR_IN, ADDR_A_LO)) begin
        a_lo <= SFR_WR_IN.data;
      end
      if (hit(SFR_WR_IN, ADDR_A_HI)) begin
        a_hi <= SFR_WR_IN.data;
      end
      if (wr_b_lo) begin
        b_lo <= SFR_WR_IN.data;
      end
      if (hit(SFR_WR_IN, ADDR_B_HI)) begin
        b_hi <= SFR_WR_IN.data;
      end
    end
  end

  // Pipeline markers: multiply, accumulate, round
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      shift_done <= 1'b0;
      acc0_done <= 1'b0;
    end else if (CE_IN) begin
      stage1 <= wr_b_lo;
      stage2 <= stage1;
      stage3 <= do_mac;
      shift_done <= do_shift;
      acc0_done <= hit(SFR_WR_IN, ADDR_ACC[0]);
    end
  end

  mac_mult #(
    .OPW(16),
    .PW(ACC_W)
  ) u_mult (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .en_in(stage1),
    .frac_in(cfg.fractional_select),
    .a_in({a_hi, a_lo}),
    .b_in({b_hi, b_lo}),
    .product_out(product)
  );

  mac_round u_round (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .en_in(round_go),
    .sat_in(cfg.saturation_enable),
    .acc_in(acc),
    .rnd_out(rnd)
  );

  // Multiply only adds the product to zero
  assign mac_sum = cfg.operation_select ? product : acc + product;
  assign top_wrap = ((acc[39:32] == TOP_POS_EDGE) && (mac_sum[39:32] == TOP_NEG_EDGE))
    || ((acc[39:32] == TOP_NEG_EDGE) && (mac_sum[39:32] == TOP_POS_EDGE));

  // Software byte writes merged over the current accumulator
  always_comb begin
    sw_acc = acc;
    sw_acc_wr = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (hit(SFR_WR_IN, ADDR_ACC[i])) begin
        sw_acc[8*i +: 8] = SFR_WR_IN.data;
        sw_acc_wr = 1'b1;
      end
    end
  end

  // Accumulator
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      acc <= '0;
    end else if (CE_IN) begin
      if (do_clear) begin
        acc <= '0;
      end else if (do_mac) begin
        acc <= mac_sum;
      end else if (do_shift) begin
        if (cfg.shift_direction) begin
          acc <= {acc[ACC_W-1], acc[ACC_W-1:1]};
        end else begin
          acc <= {acc[ACC_W-2:0], 1'b0};
        end
      end else if (sw_acc_wr) begin
        acc <= sw_acc;
      end
    end
  end

  // Configuration; a software write in the same cycle wins over self-clear
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      cfg <= mac_cfg_t'(CFG_RESET);
    end else if (CE_IN) begin
      if (wr_cfg) begin
        cfg <= mac_cfg_t'(SFR_WR_IN.data & CFG_WMASK);
      end else begin
        if (do_clear) begin
          cfg.accumulator_clear <= 1'b0;
        end
        if (do_shift) begin
          cfg.shift_request <= 1'b0;
        end
      end
    end
  end

  // Status flags; shifts leave them alone
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      sta <= mac_status_t'(STA_RESET);
    end else if (CE_IN) begin
      if (do_clear) begin
        sta <= mac_status_t'(STA_RESET);
      end else if (do_mac) begin
        sta.zero_flag <= (mac_sum == '0);
        sta.negative_flag <= mac_sum[ACC_W-1];
        sta.soft_overflow_flag <= soft_ovf(mac_sum);
        if (!cfg.operation_select && top_wrap) begin
          sta.hard_overflow_flag <= 1'b1;
        end else if (wr_sta) begin
          sta.hard_overflow_flag <= SFR_WR_IN.data[3];
        end
      end else if (wr_sta) begin
        sta <= mac_status_t'(SFR_WR_IN.data & STA_WMASK);
      end
    end
  end

  // Registered read port; unmapped addresses read zero
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      SFR_RDATA_OUT <= BYTE_RESET;
    end else if (CE_IN && SFR_RD_IN) begin
      case (SFR_RADDR_IN)
        ADDR_A_LO: SFR_RDATA_OUT <= a_lo;
        ADDR_A_HI: SFR_RDATA_OUT <= a_hi;
        ADDR_B_LO: SFR_RDATA_OUT <= b_lo;
        ADDR_B_HI: SFR_RDATA_OUT <= b_hi;
        ADDR_CFG: SFR_RDATA_OUT <= cfg;
        ADDR_STA: SFR_RDATA_OUT <= sta;
        ADDR_ACC[0]: SFR_RDATA_OUT <= acc[7:0];
        ADDR_ACC[1]: SFR_RDATA_OUT <= acc[15:8];
        ADDR_ACC[2]: SFR_RDATA_OUT <= acc[23:16];
        ADDR_ACC[3]: SFR_RDATA_OUT <= acc[31:24];
        ADDR_ACC[4]: SFR_RDATA_OUT <= acc[39:32];
        ADDR_RND_HI: SFR_RDATA_OUT <= rnd[15:8];
        ADDR_RND_LO: SFR_RDATA_OUT <= rnd[7:0];
        default: SFR_RDATA_OUT <= BYTE_RESET;
      endcase
    end
  end

  // Checks; multi-cycle ones assume the clock enable stays high
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  // Operands widened here so the product check does not reuse the multiplier
  logic [ACC_W-1:0] a_ext;
  logic [ACC_W-1:0] b_ext;
  assign a_ext = {{(ACC_W-16){a_hi[7]}}, a_hi, a_lo};
  assign b_ext = {{(ACC_W-16){b_hi[7]}}, b_hi, b_lo};

  sequence s_round_plain;
    CE_IN && round_go && !cfg.saturation_enable;
  endsequence

  sequence s_round_sat;
    CE_IN && round_go && cfg.saturation_enable;
  endsequence

  sequence s_read_taken;
    CE_IN && SFR_RD_IN;
  endsequence

  sequence s_start;
    CE_IN && wr_b_lo;
  endsequence

  sequence s_run_two;
    CE_IN ##1 CE_IN;
  endsequence

  a_start_pipeline: assert property (s_start ##1 s_run_two |-> stage2 || do_clear)
    else $error("operand write did not reach accumulate stage in two cycles");

  a_product_int: assert property (CE_IN && stage1 && !cfg.fractional_select
    |=> product == $past(a_ext * b_ext))
    else $error("integer product wrong");

  a_product_frac: assert property (CE_IN && stage1 && cfg.fractional_select
    |=> product == ($past(a_ext * b_ext) << 1))
    else $error("fractional product not doubled");

  a_shift_left_value: assert property (CE_IN && do_shift && !cfg.shift_direction
    |=> acc == {$past(acc[ACC_W-2:0]), 1'b0})
    else $error("left shift gave wrong accumulator");

  a_shift_right_sign: assert property (CE_IN && do_shift && cfg.shift_direction
    |=> acc == {$past(acc[ACC_W-1]), $past(acc[ACC_W-1:1])})
    else $error("right shift lost the sign bit");

  a_shift_self_clear: assert property (CE_IN && do_shift && !wr_cfg
    |=> !cfg.shift_request && $stable(sta))
    else $error("shift request bit not cleared after shift");

  a_clear_zeroes_all: assert property (CE_IN && do_clear && !wr_cfg
    |=> acc == '0 && sta == mac_status_t'(STA_RESET) && !cfg.accumulator_clear)
    else $error("clear did not zero accumulator and status");

  a_upper_bits_zero: assert property (cfg.unused == 2'b00 && sta.unused == 4'h0)
    else $error("unused register bits not zero");

  a_config_write: assert property (CE_IN && wr_cfg
    |=> cfg == mac_cfg_t'($past(SFR_WR_IN.data) & CFG_WMASK))
    else $error("configuration write not taken as masked value");

  a_status_write: assert property (CE_IN && wr_sta && !do_mac && !do_clear
    |=> sta == mac_status_t'($past(SFR_WR_IN.data) & STA_WMASK))
    else $error("status write not taken as masked value");

  a_mult_only_over: assert property (CE_IN && do_mac && cfg.operation_select
    |=> acc == $past(product) && sta.hard_overflow_flag == $past(sta.hard_overflow_flag))
    else $error("multiply only did not overwrite or touched hard overflow");

  a_flags_follow: assert property (CE_IN && do_mac
    |=> sta.zero_flag == (acc == '0) && sta.negative_flag == acc[ACC_W-1]
    && sta.soft_overflow_flag == soft_ovf(acc))
    else $error("zero, negative or soft overflow flag wrong after operation");

  a_hard_ovf_sticks: assert property (CE_IN && sta.hard_overflow_flag && !do_clear
    && !wr_sta |=> sta.hard_overflow_flag)
    else $error("hard overflow flag dropped without clear or write");

  a_hard_ovf_write: assert property (CE_IN && wr_sta && !SFR_WR_IN.data[3]
    && !(do_mac && !cfg.operation_select && top_wrap) |=> !sta.hard_overflow_flag)
    else $error("hard overflow flag not cleared by software write");

  a_wrap_sets_hard: assert property (CE_IN && do_mac && !cfg.operation_select
    && top_wrap |=> sta.hard_overflow_flag)
    else $error("top byte wrap did not set hard overflow");

  a_round_tie_even: assert property (s_round_plain
    ##0 acc[15:0] == RND_HALF && !acc[16] |=> rnd == $past(acc[31:16]))
    else $error("tie with even word was not rounded down");

  a_round_up: assert property (s_round_plain
    ##0 acc[15:0] > RND_HALF |=> rnd == $past(acc[31:16]) + 16'h0001)
    else $error("low word above one half was not rounded up");

  a_round_down: assert property (s_round_plain
    ##0 acc[15:0] < RND_HALF |=> rnd == $past(acc[31:16]))
    else $error("low word below one half was not rounded down");

  a_sat_positive: assert property (s_round_sat
    ##0 soft_ovf(acc) && !acc[ACC_W-1] |=> rnd == SAT_POS)
    else $error("positive overflow did not saturate");

  a_sat_negative: assert property (s_round_sat
    ##0 soft_ovf(acc) && acc[ACC_W-1] |=> rnd == SAT_NEG)
    else $error("negative overflow did not saturate");

  a_read_config: assert property (s_read_taken ##0 SFR_RADDR_IN == ADDR_CFG
    |=> SFR_RDATA_OUT == $past(cfg))
    else $error("configuration read returned wrong byte");

  a_read_status: assert property (s_read_taken ##0 SFR_RADDR_IN == ADDR_STA
    |=> SFR_RDATA_OUT == $past(sta))
    else $error("status read returned wrong byte");

  a_read_round_hi: assert property (s_read_taken ##0 SFR_RADDR_IN == ADDR_RND_HI
    |=> SFR_RDATA_OUT == $past(rnd[15:8]))
    else $error("rounding high read returned wrong byte");

  a_acc_top_write: assert property (CE_IN && hit(SFR_WR_IN, ADDR_ACC[4])
    && !do_clear && !do_mac && !do_shift |=> acc[ACC_W-1:32] == $past(SFR_WR_IN.data))
    else $error("top accumulator byte write not taken");
endmodule

//--- tb/mac_host_model.sv
// Host core model driving the unit's byte register bus.
// Assumes the unit samples requests on the rising clock edge.
`timescale 1ns/1ns
module mac_host_model (
  input wire logic clk_in,
  output mac_pkg::mac_sfr_wr_t wr_out,
  output logic rd_out,
  output logic [7:0] raddr_out,
  input wire logic [7:0] rdata_in
);
  import mac_pkg::*;
  initial begin
    wr_out = '0;
    rd_out = 1'b0;
    raddr_out = 8'h00;
  end
  // Valid stays up so writes may run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_out = {1'b1, a, d};
  endtask
  // Bus kept quiet while the pipeline runs
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk_in);
      wr_out.valid = 1'b0;
    end
  endtask
  // Strobe dropped a cycle later, so reads never overlap
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    wr_out.valid = 1'b0;
    rd_out = 1'b1;
    raddr_out = a;
    @(negedge clk_in);
    rd_out = 1'b0;
    d = rdata_in;
  endtask
endmodule

//--- tb/multiply_accumulate_unit_test.sv
// Self-checking bench of the multiply-accumulate unit.
// Assumes reads answer one cycle after the strobe.
`timescale 1ns/1ns
module multiply_accumulate_unit_test;
  import mac_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  mac_sfr_wr_t wr;
  logic rd;
  logic [7:0] raddr;
  logic [7:0] rdata;
  logic [7:0] got;
  logic [39:0] e_acc;
  logic [15:0] e_rnd;
  logic [7:0] e_cfg;
  logic [7:0] e_sta;
  logic [15:0] ra;
  logic [15:0] rb;
  int n_mismatch = 0;
  int tests_run = 0;

  always #20 sys_clk = ~sys_clk;

  mac_unit u_dut (.SYS_CLK_IN(sys_clk), .RST_IN(rst), .CE_IN(ce), .SFR_WR_IN(wr),
    .SFR_RD_IN(rd), .SFR_RADDR_IN(raddr), .SFR_RDATA_OUT(rdata));
  mac_host_model u_host (.clk_in(sys_clk), .wr_out(wr), .rd_out(rd), .raddr_out(raddr),
    .rdata_in(rdata));

  function automatic logic sov(input logic [39:0] v);
    return (v[39:31] != 9'h000) && (v[39:31] != 9'h1ff);
  endfunction

  function automatic logic [15:0] rnd_of(input logic [39:0] v, input logic sat);
    logic up;
    up = (v[15:0] > 16'h8000) || (v[15:0] == 16'h8000 && v[16]);
    if (sat && (sov(v) || (up && v[31:16] == 16'h7fff))) begin
      return v[39] ? 16'h8000 : 16'h7fff;
    end
    return v[31:16] + {15'h0000, up};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t addr %h got %h exp %h", $time, a, got, exp);
    end
  endtask

  task automatic chk_all();
    for (int i = 0; i < 5; i++) begin
      chk(ADDR_ACC[i], e_acc[8*i +: 8]);
    end
    chk(ADDR_RND_HI, e_rnd[15:8]);
    chk(ADDR_RND_LO, e_rnd[7:0]);
    chk(ADDR_STA, e_sta);
  endtask

  task automatic wsta(input logic [7:0] v);
    u_host.wr(ADDR_STA, v);
    u_host.idle(1);
    e_sta = v & 8'h0f;
    chk(ADDR_STA, e_sta);
  endtask

  task automatic op(input logic [15:0] a, input logic [15:0] b, input logic [2:0] m);
    logic [39:0] p;
    logic [39:0] prev;
    logic ho;
    e_cfg = {5'h00, m};
    u_host.wr(ADDR_CFG, e_cfg);
    u_host.wr(ADDR_A_HI, a[15:8]);
    u_host.wr(ADDR_A_LO, a[7:0]);
    u_host.wr(ADDR_B_HI, b[15:8]);
    u_host.wr(ADDR_B_LO, b[7:0]);
    u_host.idle(4);
    p = {{24{a[15]}}, a} * {{24{b[15]}}, b};
    if (m[1]) begin
      p = p << 1;
    end
    prev = e_acc;
    e_acc = m[0] ? p : e_acc + p;
    ho = e_sta[3] | (!m[0] && ((prev[39:32] == 8'h7f && e_acc[39:32] == 8'h80)
      || (prev[39:32] == 8'h80 && e_acc[39:32] == 8'h7f)));
    e_sta = {4'h0, ho, e_acc == 40'h0, sov(e_acc), e_acc[39]};
    e_rnd = rnd_of(e_acc, m[2]);
    chk(ADDR_A_HI, a[15:8]);
    chk_all();
  endtask

  task automatic load(input logic [39:0] v);
    for (int i = 4; i >= 0; i--) begin
      u_host.wr(ADDR_ACC[i], v[8*i +: 8]);
    end
    u_host.idle(2);
    e_acc = v;
    e_rnd = rnd_of(v, e_cfg[2]);
    chk_all();
  endtask

  // Back-to-back requests give one shift each
  task automatic shift(input int n, input logic dir);
    for (int i = 0; i < n; i++) begin
      u_host.wr(ADDR_CFG, e_cfg | {3'b001, dir, 4'h0});
      e_acc = dir ? {e_acc[39], e_acc[39:1]} : {e_acc[38:0], 1'b0};
    end
    u_host.idle(3);
    e_rnd = rnd_of(e_acc, e_cfg[2]);
    e_cfg = (e_cfg & 8'h0f) | {3'b000, dir, 4'h0};
    chk(ADDR_CFG, e_cfg);
    chk_all();
  endtask

  task automatic clr();
    u_host.wr(ADDR_CFG, e_cfg | 8'h08);
    u_host.idle(3);
    e_acc = 40'h0;
    e_sta = 8'h04;
    chk(ADDR_CFG, e_cfg);
    chk_all();
  endtask

  task automatic rst_chk();
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    e_acc = 40'h0;
    e_rnd = 16'h0000;
    e_cfg = 8'h00;
    e_sta = 8'h04;
    chk(ADDR_CFG, 8'h00);
    chk(ADDR_A_LO, 8'h00);
    chk(ADDR_B_HI, 8'h00);
    chk(8'h00, 8'h00);
    chk_all();
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk);
    n_mismatch++;
    $display("timeout reached");
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h58e2));
    rst_chk();
    u_host.wr(ADDR_CFG, 8'hc7);
    u_host.idle(1);
    e_cfg = 8'h07;
    chk(ADDR_CFG, e_cfg);
    wsta(8'hff);
    op(16'h4000, 16'h2000, 3'b010);
    op(16'h4000, 16'he000, 3'b010);
    wsta(8'h00);
    op(16'h1234, 16'hfedc, 3'b001);
    load(40'h4088442211);
    shift(1, 1'b0);
    shift(2, 1'b1);
    clr();
    load(40'h7fffffffff);
    op(16'h0001, 16'h0001, 3'b100);
    wsta(8'h00);
    op(16'h0002, 16'hffff, 3'b000);
    load(40'h0000018000);
    load(40'h0000028000);
    load(40'h0100000000);
    op(16'h0000, 16'h0000, 3'b000);
    load(40'h007fff8000);
    op(16'h7fff, 16'h7fff, 3'b101);
    load(40'h0080000000);
    load(40'hff7fffffff);
    load(40'h007fff8001);
    // Clock enable low must freeze the write for the two to four cycles that it stays low
    ra = 16'($urandom);
    @(negedge sys_clk);
    ce = 1'b0;
    u_host.wr(ADDR_A_LO, ~ra[7:0]);
    u_host.idle($urandom_range(3, 1));
    ce = 1'b1;
    chk(ADDR_A_LO, 8'hff);
    u_host.wr(ADDR_A_LO, ra[7:0]);
    u_host.idle(1);
    chk(ADDR_A_LO, ra[7:0]);
    repeat (40) begin
      ra = 16'($urandom);
      rb = 16'($urandom);
      op(ra, rb, 3'($urandom));
      if ($urandom_range(3) == 0) begin
        shift(1, 1'($urandom));
      end
    end
    clr();
    rst_chk();
    tally_and_finish();
  end
endmodule
